// *** design/dpa_core.sv ***
// DMA descriptor address generator and fourteen-channel priority arbiter.
// Functional notes
// - Index plus modify written back each transfer.
// - Modify fields sign-extended to 32 bits.
// - Count drops by 1, 2 or 4.
// - Zero count ends block, flags done.
// - Zero-loaded count still runs, wraps first.
// - External channels carry second address descriptor.
// - Two-dim counts rows; shorter block ends.
// - Reset disables all but boot channel.
// - Fixed groups: slave, receive, transmit, external.
// - Arbitration every cycle; higher preempts.
// - Chain loads arbitrate at channel priority.
// - Urgent channel tops its group.
// - External rotation resets to 3,2,1,0.
// - Granted external channel moves to top.
// - Higher groups leave external rotation untouched.
// - Urgent external channels in upper round robin.
// - Urgent preempts; lower rotation stays intact.
// - Several urgent channels: last granted stays on top, wins again.
// - Size codes 1,2,3; boot uses normal.
// - Nonzero kind means enabled.
`timescale 1ns/100ps
`default_nettype none
module dpa_core #(
  parameter int BOOT_CH = 0
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset_n,
  input  wire logic [dpa_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  output logic [1:0]                      o_bresp,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  input  wire logic [dpa_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  input  wire logic [dpa_pkg::NUM_CH-1:0] i_xfer_req,
  input  wire logic [dpa_pkg::NUM_CH-1:0] i_chain_req,
  input  wire logic [2:0]                 i_bus_ready,
  output dpa_pkg::dpa_grant_t             o_grant,
  output logic [dpa_pkg::NUM_CH-1:0]      o_block_done
);
  import dpa_pkg::*;

  localparam logic [NUM_CH-1:0] LIVE_RESET = NUM_CH'(1) << BOOT_CH;

  function automatic logic [31:0] sx16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic [15:0] size_step(input logic [1:0] s);
    case (s)
      SIZE_LONG: return STEP_LONG;
      SIZE_QUAD: return STEP_QUAD;
      default:   return STEP_NORMAL;
    endcase
  endfunction

  function automatic logic [4:0] pick_hi(input logic [NUM_CH-1:0] m);
    logic [4:0] r;
    r = 5'h0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (m[c]) r = {1'b1, 4'(c)};
    end
    return r;
  endfunction

  function automatic logic [4:0] pick_grp(input logic [NUM_CH-1:0] rq,
                                          input logic [NUM_CH-1:0] ur,
                                          input logic [NUM_CH-1:0] gm);
    logic [NUM_CH-1:0] m;
    m = rq & gm;
    return pick_hi(|(m & ur) ? (m & ur) : m);
  endfunction

  function automatic logic [NUM_CH-1:0] grp_of(input logic [3:0] ch);
    if (ch >= 4'd12) return GRP_SLV;
    else if (ch >= 4'd8) return GRP_RCV;
    else if (ch >= 4'd4) return GRP_XMT;
    else return GRP_EP;
  endfunction

  function automatic dpa_dec_t decode(input logic [ADDR_W-1:0] a);
    dpa_dec_t d;
    d = '0;
    d.ch   = a[7:4];
    d.rsel = a[3:2];
    if (a[1:0] != 2'h0) begin
      d.ok = 1'b0;
    end else if (a == STATUS_ADDR) begin
      d.ok     = 1'b1;
      d.status = 1'b1;
    end else if (a < EXT_BASE) begin
      d.ok = a[7:4] < 4'(NUM_CH);
    end else begin
      d.ext = 1'b1;
      d.ok  = (a[7:4] < 4'(NUM_EP)) && (a[3:2] < EXT_REGS);
    end
    return d;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  // Descriptor and state storage.
  logic [31:0]       idx_r   [NUM_CH];
  logic [15:0]       xcnt_r  [NUM_CH];
  logic [15:0]       xinit_r [NUM_CH];
  logic [15:0]       xmod_r  [NUM_CH];
  logic [15:0]       ycnt_r  [NUM_CH];
  logic [15:0]       ymod_r  [NUM_CH];
  logic [CTL_W-1:0]  ctl_r   [NUM_CH];
  logic [31:0]       eidx_r  [NUM_EP];
  logic [15:0]       ecnt_r  [NUM_EP];
  logic [15:0]       emod_r  [NUM_EP];
  logic [NUM_CH-1:0] live_r;
  logic [1:0]        u_top;
  logic [1:0]        n_top;

  function automatic logic [31:0] reg_word(input dpa_dec_t d);
    if (!d.ok) return 32'h0;
    if (d.status) return {8'h0, 2'h0, n_top, 2'h0, u_top, 2'h0, live_r};
    if (d.ext) begin
      if (d.rsel == REG_INDEX) return eidx_r[d.ch[1:0]];
      return {emod_r[d.ch[1:0]], ecnt_r[d.ch[1:0]]};
    end
    case (d.rsel)
      REG_INDEX: return idx_r[d.ch];
      REG_XAXIS: return {xmod_r[d.ch], xcnt_r[d.ch]};
      REG_YAXIS: return {ymod_r[d.ch], ycnt_r[d.ch]};
      default:   return {25'h0, ctl_r[d.ch]};
    endcase
  endfunction

  // Write channel of the register slave.
  logic              aw_full_r;
  logic              w_full_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              wr_en;
  logic              wr_go;
  dpa_dec_t          wdec;
  logic [31:0]       wr_word;

  assign o_awready = !aw_full_r && !o_bvalid;
  assign o_wready  = !w_full_r && !o_bvalid;
  assign wr_en     = aw_full_r && w_full_r && !o_bvalid;
  assign wdec      = decode(awaddr_r);
  assign wr_go     = wr_en && wdec.ok && !wdec.status;
  assign wr_word   = merge(reg_word(wdec), wdata_r, wstrb_r);

  // Address and data are held until both are present, then answered.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
    end else begin
      if (o_awready && i_awvalid) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end else if (wr_en) begin
        aw_full_r <= 1'b0;
      end
      if (o_wready && i_wvalid) begin
        w_full_r <= 1'b1;
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
      end else if (wr_en) begin
        w_full_r <= 1'b0;
      end
      if (wr_en) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_go ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, data registered.
  dpa_dec_t rdec;
  assign rdec      = decode(i_araddr);
  assign o_arready = !o_rvalid;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
      o_rresp  <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= reg_word(rdec);
      o_rresp  <= rdec.ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Requesting channels: armed, kind nonzero, data or chain request raised.
  logic [NUM_CH-1:0] arb_req;
  logic [NUM_CH-1:0] urg;
  logic              u_valid;
  logic              n_valid;
  logic [1:0]        u_pick;
  logic [1:0]        n_pick;
  logic [4:0]        win;
  logic              from_u;
  logic              from_n;
  logic              grant_go;
  logic [3:0]        w;
  logic              w_chain;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      arb_req[c] = live_r[c] && (ctl_r[c][CTL_KIND_LSB +: 3] != KIND_OFF) &&
                   (i_xfer_req[c] || i_chain_req[c]);
      urg[c]     = ctl_r[c][CTL_URG_BIT];
    end
  end

  // Fixed group order, urgent first inside a group, rotation for the ports.
  always_comb begin
    from_u = 1'b0;
    from_n = 1'b0;
    if (|(arb_req & GRP_SLV)) begin
      win = pick_grp(arb_req, urg, GRP_SLV);
    end else if (|(arb_req & GRP_RCV)) begin
      win = pick_grp(arb_req, urg, GRP_RCV);
    end else if (|(arb_req & GRP_XMT)) begin
      win = pick_grp(arb_req, urg, GRP_XMT);
    end else if (u_valid) begin
      win    = {3'b100, u_pick};
      from_u = 1'b1;
    end else if (n_valid) begin
      win    = {3'b100, n_pick};
      from_n = 1'b1;
    end else begin
      win = 5'h0;
    end
  end

  assign grant_go = win[4] && (|i_bus_ready);
  assign w        = win[3:0];
  assign w_chain  = !i_xfer_req[w];

  dpa_rr4 u_rr_urgent (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_req      (arb_req[3:0] & urg[3:0]),
    .i_take     (grant_go && from_u),
    .o_valid    (u_valid),
    .o_pick     (u_pick),
    .o_top      (u_top)
  );

  dpa_rr4 u_rr_normal (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_req      (arb_req[3:0] & ~urg[3:0]),
    .i_take     (grant_go && from_n),
    .o_valid    (n_valid),
    .o_pick     (n_pick),
    .o_top      (n_top)
  );

  // Next descriptor values of the winning channel.
  logic [1:0]  w_size;
  logic [15:0] step;
  logic [15:0] x_next;
  logic [15:0] e_next;
  logic        row_end;
  logic        jump;
  logic        last;
  logic [31:0] nx_idx;

  assign w_size  = ctl_r[w][CTL_SIZE_LSB +: 2];
  assign step    = size_step(w_size);
  assign x_next  = xcnt_r[w] - step;
  assign row_end = x_next == 16'h0;
  assign jump    = row_end && ctl_r[w][CTL_2D_BIT] && (ycnt_r[w] != 16'h1);
  assign e_next  = ecnt_r[w[1:0]] - step;
  assign last    = (row_end && !jump) || (w < 4'(NUM_EP) && e_next == 16'h0);
  assign nx_idx  = idx_r[w] + sx16(xmod_r[w]) + (jump ? sx16(ymod_r[w]) : 32'h0);

  // Descriptors: a channel granted a data transfer steps, a chain load does not; a software write to a field wins.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        idx_r[c]   <= 32'h0;
        xcnt_r[c]  <= 16'h0;
        xinit_r[c] <= 16'h0;
        xmod_r[c]  <= 16'h0;
        ycnt_r[c]  <= 16'h0;
        ymod_r[c]  <= 16'h0;
        ctl_r[c]   <= (c == BOOT_CH) ? CTL_BOOT : CTL_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (grant_go && !w_chain && w == 4'(c)) begin
          idx_r[c]  <= nx_idx;
          xcnt_r[c] <= jump ? xinit_r[c] : x_next;
          if (jump) ycnt_r[c] <= ycnt_r[c] - 16'h1;
        end
        if (wr_go && !wdec.ext && wdec.ch == 4'(c)) begin
          case (wdec.rsel)
            REG_INDEX: idx_r[c] <= wr_word;
            REG_XAXIS: begin
              xcnt_r[c]  <= wr_word[15:0];
              xinit_r[c] <= wr_word[15:0];
              xmod_r[c]  <= wr_word[31:16];
            end
            REG_YAXIS: begin
              ycnt_r[c] <= wr_word[15:0];
              ymod_r[c] <= wr_word[31:16];
            end
            default: ctl_r[c] <= wr_word[CTL_W-1:0];
          endcase
        end
      end
    end
  end

  // External address descriptors of the port channels.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int e = 0; e < NUM_EP; e++) begin
        eidx_r[e] <= 32'h0;
        ecnt_r[e] <= 16'h0;
        emod_r[e] <= 16'h0;
      end
    end else begin
      for (int e = 0; e < NUM_EP; e++) begin
        if (grant_go && !w_chain && w == 4'(e)) begin
          eidx_r[e] <= eidx_r[e] + sx16(emod_r[e]);
          ecnt_r[e] <= e_next;
        end
        if (wr_go && wdec.ext && wdec.ch == 4'(e)) begin
          if (wdec.rsel == REG_INDEX) begin
            eidx_r[e] <= wr_word;
          end else begin
            ecnt_r[e] <= wr_word[15:0];
            emod_r[e] <= wr_word[31:16];
          end
        end
      end
    end
  end

  // Writing a nonzero kind to the control word arms the channel; the last transfer disarms it.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      live_r       <= LIVE_RESET;
      o_block_done <= '0;
    end else begin
      o_block_done <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        if (grant_go && !w_chain && w == 4'(c) && last) begin
          live_r[c]       <= 1'b0;
          o_block_done[c] <= 1'b1;
        end
        if (wr_go && !wdec.ext && wdec.ch == 4'(c) && wdec.rsel == REG_CTL) begin
          live_r[c] <= wr_word[CTL_KIND_LSB +: 3] != KIND_OFF;
        end
      end
    end
  end

  // Grant output, one per cycle on the first ready bus.
  logic        g_jump_r;
  logic [15:0] g_oldx_r;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_grant  <= '0;
      g_jump_r <= 1'b0;
      g_oldx_r <= 16'h0;
    end else begin
      o_grant.valid <= grant_go;
      if (grant_go) begin
        o_grant.chan     <= w;
        o_grant.chain    <= w_chain;
        o_grant.bus      <= i_bus_ready[0] ? 2'h0 : (i_bus_ready[1] ? 2'h1 : 2'h2);
        o_grant.size     <= w_size;
        o_grant.addr     <= idx_r[w];
        o_grant.ext_addr <= (w < 4'(NUM_EP)) ? eidx_r[w[1:0]] : 32'h0;
        g_jump_r         <= jump;
        g_oldx_r         <= xcnt_r[w];
      end
    end
  end

  chk_index_step_add: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_grant.valid && !o_grant.chain && !g_jump_r |->
      idx_r[o_grant.chan] == o_grant.addr + sx16(xmod_r[o_grant.chan]))
    else $error("Index did not advance by the signed modify.");

  chk_count_step_size: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_grant.valid && !o_grant.chain && !g_jump_r |->
      xcnt_r[o_grant.chan] == g_oldx_r - size_step(o_grant.size))
    else $error("Count did not drop by the operand size.");

  chk_done_disarms: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    |o_block_done |-> !(|(o_block_done & live_r)) && $past(grant_go))
    else $error("Finished channel still armed.");

  chk_fixed_group: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    win[4] |-> (win[3:0] < 4'd4 ? !(|(arb_req & ~GRP_EP)) :
               !(|(arb_req & ~grp_of(win[3:0]) & ~((NUM_CH'(1) << win[3:0]) - 1'b1)))))
    else $error("A lower group won over a higher one.");

  chk_urgent_group: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    win[4] && |(arb_req & urg & grp_of(win[3:0])) |-> urg[win[3:0]])
    else $error("Unflagged channel beat an urgent one in its group.");

  chk_kind_enable: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    grant_go |-> ctl_r[w][CTL_KIND_LSB +: 3] != KIND_OFF)
    else $error("Grant to a channel whose kind is zero.");

  chk_bus_ready: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_grant.valid |-> |($past(i_bus_ready) & (3'h1 << o_grant.bus)))
    else $error("Grant issued on a bus that was not ready.");

  chk_rot_kept_high: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    grant_go && w >= 4'd4 |=> $stable(n_top) && $stable(u_top))
    else $error("Port rotation moved while a higher group was served.");

  chk_low_rot_intact: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    grant_go && from_u |=> $stable(n_top))
    else $error("Urgent grant disturbed the lower rotation.");

  chk_urgent_port: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    win[4] && w < 4'd4 && |(arb_req[3:0] & urg[3:0]) |-> urg[w])
    else $error("Unflagged port channel beat an urgent one.");
endmodule // dpa_core
`default_nettype wire

// *** design/dpa_pkg.sv ***
// Shared constants and carrier types of the DMA address and priority arbiter.
package dpa_pkg;
  localparam int NUM_CH = 14;
  localparam int NUM_EP = 4;
  localparam int ADDR_W = 9;
  // Register map: channel block c at c*0x10, external blocks, then status.
  localparam logic [8:0] EXT_BASE    = 9'h100;
  localparam logic [8:0] STATUS_ADDR = 9'h180;
  localparam logic [1:0] REG_INDEX   = 2'h0;
  localparam logic [1:0] REG_XAXIS   = 2'h1;
  localparam logic [1:0] REG_YAXIS   = 2'h2;
  localparam logic [1:0] REG_CTL     = 2'h3;
  localparam logic [1:0] EXT_REGS    = 2'h2;
  // Control word fields.
  localparam int CTL_W        = 7;
  localparam int CTL_KIND_LSB = 0;
  localparam int CTL_SIZE_LSB = 3;
  localparam int CTL_URG_BIT  = 5;
  localparam int CTL_2D_BIT   = 6;
  localparam logic [2:0] KIND_OFF    = 3'h0;
  localparam logic [1:0] SIZE_NORMAL = 2'h1;
  localparam logic [1:0] SIZE_LONG   = 2'h2;
  localparam logic [1:0] SIZE_QUAD   = 2'h3;
  localparam logic [15:0] STEP_NORMAL = 16'h1;
  localparam logic [15:0] STEP_LONG   = 16'h2;
  localparam logic [15:0] STEP_QUAD   = 16'h4;
  localparam logic [CTL_W-1:0] CTL_RESET = 7'h00;
  localparam logic [CTL_W-1:0] CTL_BOOT  = 7'h0a;
  // Status word fields.
  localparam int STAT_UTOP_LSB = 16;
  localparam int STAT_NTOP_LSB = 20;
  // Rotation pointer after reset: channel 3 on top.
  localparam logic [1:0] ROT_RESET = 2'h3;
  // Priority groups.
  localparam logic [13:0] GRP_SLV = 14'h3000;
  localparam logic [13:0] GRP_RCV = 14'h0f00;
  localparam logic [13:0] GRP_XMT = 14'h00f0;
  localparam logic [13:0] GRP_EP  = 14'h000f;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        valid;
    logic        chain;
    logic [3:0]  chan;
    logic [1:0]  bus;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] ext_addr;
  } dpa_grant_t;

  typedef struct packed {
    logic       ok;
    logic       ext;
    logic       status;
    logic [3:0] ch;
    logic [1:0] rsel;
  } dpa_dec_t;
endpackage

// *** design/dpa_rr4.sv ***
// Four-way rotating priority picker for the external-port channels.
`timescale 1ns/100ps
`default_nettype none
module dpa_rr4 (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  input  wire logic [3:0] i_req,
  input  wire logic       i_take,
  output logic            o_valid,
  output logic [1:0]      o_pick,
  output logic [1:0]      o_top
);
  import dpa_pkg::*;

  logic [1:0] top_r;

  // Search downward, cyclically, from the channel on top.
  always_comb begin
    o_valid = 1'b0;
    o_pick  = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (i_req[top_r - 2'(k)]) begin
        o_valid = 1'b1;
        o_pick  = top_r - 2'(k);
      end
    end
  end

  // A new grant puts the granted channel on top; otherwise the order holds.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      top_r <= ROT_RESET;
    end else if (i_take && o_valid) begin
      top_r <= o_pick;
    end
  end

  assign o_top = top_r;

  chk_rr_rotate_top: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_take && o_valid |=> top_r == $past(o_pick))
    else $error("Rotation did not put the granted channel on top.");

  chk_rr_hold_idle: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !i_take |=> $stable(top_r))
    else $error("Rotation changed without a grant.");
endmodule // dpa_rr4
`default_nettype wire

// *** verification/dpa_src_model.sv ***
// Request sources and memory buses standing at the far side of the arbiter.
`timescale 1ns/100ps
`default_nettype none
module dpa_src_model (
  input  wire logic        i_core_clk,
  input  wire logic [13:0] i_want,
  input  wire logic [13:0] i_chain_want,
  input  wire logic        i_stall,
  output logic [13:0]      o_xfer_req,
  output logic [13:0]      o_chain_req,
  output logic [2:0]       o_bus_ready
);
  // Data and chain requests are levels that change only just after a clock edge.
  always_ff @(posedge i_core_clk) begin
    o_xfer_req  <= i_want;
    o_chain_req <= i_chain_want;
  end
  // Bus 0 is busy with core traffic, so only buses 1 and 2 are offered.
  assign o_bus_ready = i_stall ? 3'h0 : 3'h6;
endmodule // dpa_src_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the DMA address and priority arbiter.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dpa_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [8:0]  awaddr = 9'h0;
  logic [8:0]  araddr = 9'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [13:0] want = 14'h0;
  logic [13:0] cwant = 14'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [13:0] xreq, creq, done;
  logic [2:0]  bus_rdy;
  dpa_grant_t  grant;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;

  dpa_core #(.BOOT_CH(0)) dpa_core_i (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(1'b1), .i_xfer_req(xreq), .i_chain_req(creq), .i_bus_ready(bus_rdy),
    .o_grant(grant), .o_block_done(done));
  dpa_src_model dpa_src_model_i (.i_core_clk(clk), .i_want(want), .i_chain_want(cwant),
    .i_stall(stall),
    .o_xfer_req(xreq), .o_chain_req(creq), .o_bus_ready(bus_rdy));

  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Writes one register word and waits for the response.
  task automatic axw(input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 20);
    chk(bvalid === 1'b1 && bresp === RESP_OKAY, "write response");
  endtask

  // Reads one register word, taking data and response at the answer edge.
  task automatic axr(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 20);
    chk(rvalid === 1'b1, "read answer");
    d = rdata;
    r = rresp;
  endtask

  // Skips some edges, then judges the next grant seen.
  task automatic gnt(input int sk, input logic [3:0] c, input logic [31:0] a,
                     input logic dn);
    int n;
    n = 0;
    repeat (sk) @(posedge clk);
    do begin
      @(posedge clk);
      n++;
    end while (grant.valid !== 1'b1 && n < 20);
    chk(grant.valid === 1'b1 && grant.chan === c && grant.addr === a && done[c] === dn &&
        grant.bus === 2'h1, "grant channel, address, bus or done");
  endtask

  // Expects no grant at all over ten cycles.
  task automatic quiet(input string m);
    int n;
    n = 0;
    repeat (10) begin
      @(posedge clk);
      if (grant.valid !== 1'b0) n++;
    end
    chk(n == 0, m);
  endtask

  // Reset values of control and status words, and an unmapped read.
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    axr(9'h00c, d, r);
    chk(d[6:0] === CTL_BOOT && r === RESP_OKAY, "boot control");
    axr(9'h01c, d, r);
    chk(d[6:0] === CTL_RESET, "idle control");
    axr(STATUS_ADDR, d, r);
    chk(d[21:20] === ROT_RESET && d[17:16] === ROT_RESET, "rotation reset");
    axr(9'h1f0, d, r);
    chk(r === RESP_SLVERR && d === 32'h0, "unmapped read");
    $display("test reset done");
  endtask

  // Descending long-word block of four words, then disarm and stall.
  task automatic t_step;
    axw(9'h050, 32'h00001000);
    axw(9'h054, 32'hfffc0008);
    axw(9'h05c, 32'h00000012);
    want <= 14'h0020;
    gnt(0, 4'h5, 32'h00001000, 1'b0);
    gnt(0, 4'h5, 32'h00000ffc, 1'b0);
    gnt(0, 4'h5, 32'h00000ff8, 1'b0);
    gnt(0, 4'h5, 32'h00000ff4, 1'b1);
    axw(9'h05c, 32'h00000012);
    gnt(0, 4'h5, 32'h00000ff0, 1'b0);
    axw(9'h05c, 32'h0);
    quiet("disarmed channel granted");
    axw(9'h04c, 32'h0000000a);
    stall <= 1'b1;
    want  <= 14'h0010;
    quiet("grant with no bus ready");
    stall <= 1'b0;
    want  <= 14'h0;
    $display("test step done");
  endtask

  // Fixed groups, preemption, rotation and the urgent ring.
  task automatic t_prio;
    axw(9'h120, 32'h40000000);
    axw(9'h124, 32'h00100100);
    axw(9'h0dc, 32'h0000000a);
    axw(9'h01c, 32'h0000000a);
    axw(9'h02c, 32'h0000000a);
    axw(9'h03c, 32'h0000000a);
    want <= 14'h2014;
    gnt(3, 4'hd, 32'h0, 1'b0);
    want <= 14'h0014;
    gnt(3, 4'h4, 32'h0, 1'b0);
    want <= 14'h0004;
    gnt(3, 4'h2, 32'h0, 1'b0);
    chk(grant.ext_addr === 32'h40000010, "external address");
    want <= 14'h000a;
    gnt(3, 4'h1, 32'h0, 1'b0);
    axw(9'h00c, 32'h0000002a);
    want <= 14'h0003;
    gnt(3, 4'h0, 32'h0, 1'b0);
    want <= 14'h000a;
    gnt(3, 4'h1, 32'h0, 1'b0);
    want <= 14'h0;
    $display("test priority done");
  endtask

  // A data transfer outranks a lower chain load, and a chain load never steps.
  task automatic t_chain;
    axw(9'h034, 32'h00040010);
    want  <= 14'h0010;
    cwant <= 14'h0008;
    gnt(3, 4'h4, 32'h0, 1'b0);
    chk(grant.chain === 1'b0, "data grant flagged as chain");
    want <= 14'h0;
    gnt(3, 4'h3, 32'h0, 1'b0);
    chk(grant.chain === 1'b1, "chain load flag");
    gnt(0, 4'h3, 32'h0, 1'b0);
    cwant <= 14'h0;
    $display("test chain done");
  endtask

  // Two rows of two words on an urgent channel that outranks its neighbour.
  task automatic t_2d;
    axw(9'h060, 32'h00002000);
    axw(9'h064, 32'h00010002);
    axw(9'h068, 32'h00100002);
    axw(9'h07c, 32'h0000000a);
    axw(9'h06c, 32'h0000006a);
    want <= 14'h00c0;
    gnt(0, 4'h6, 32'h00002000, 1'b0);
    gnt(0, 4'h6, 32'h00002001, 1'b0);
    gnt(0, 4'h6, 32'h00002012, 1'b0);
    gnt(0, 4'h6, 32'h00002013, 1'b1);
    want <= 14'h0;
    $display("test two-dim done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  // Main sequence: reset for six cycles, then the scenarios.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_step();
    t_prio();
    t_chain();
    t_2d();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
